/* logic/afsg_status_top.sv */
// Activity and fault status groups with their command port
`timescale 1ns/1ps
`default_nettype none

module afsg_status_top
  import afsg_pkg::*;
(
  input  wire logic              ref_clk,
  input  wire logic              reset,
  // Instrument state
  input  wire logic              ref_clock_unlocked,
  input  wire logic              data_store_full,
  input  wire logic              chan_b_offset_zeroing,
  input  wire logic              chan_a_offset_zeroing,
  input  wire logic              trigger_wait,
  input  wire logic              recording_active,
  input  wire logic              ext_trigger_sel,
  input  wire logic              overtemp,
  input  wire logic              ref_signal_unlocked,
  input  wire logic              ratio_saturated,
  input  wire logic              chan_b_pre_detector_sat,
  input  wire logic              chan_b_post_detector_sat,
  input  wire logic              chan_a_pre_detector_sat,
  input  wire logic              chan_a_post_detector_sat,
  // Command port from the remote-control parser
  input  wire logic              cmd_valid,
  input  wire logic              cmd_write,
  input  wire logic [3:0]        cmd_sel,
  input  wire logic [AFSG_W-1:0] cmd_wdata,
  input  wire logic              cls_pulse,
  output logic                   rsp_valid,
  output logic [AFSG_W-1:0]      rsp_data,
  output logic                   activity_summary
);

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef struct packed {
    logic [AFSG_W-1:0] act_rise;
    logic [AFSG_W-1:0] act_fall;
    logic [AFSG_W-1:0] act_mask;
    logic [AFSG_W-1:0] act_evt;
    logic [AFSG_W-1:0] flt_rise;
    logic [AFSG_W-1:0] flt_fall;
    logic [AFSG_W-1:0] flt_mask;
    logic [AFSG_W-1:0] flt_evt;
    logic              rsp_valid;
    logic [AFSG_W-1:0] rsp_data;
    logic              summary;
  } afsg_top_state_t;

  localparam afsg_top_state_t TOP_RST = '{
    act_rise: FILTER_RST, act_fall: FILTER_RST, act_mask: MASK_RST, act_evt: EVT_RST,
    flt_rise: FILTER_RST, flt_fall: FILTER_RST, flt_mask: MASK_RST, flt_evt: EVT_RST,
    rsp_valid: 1'b0, rsp_data: '0, summary: 1'b0
  };

  afsg_top_state_t q;
  afsg_top_state_t d;

  logic [AFSG_W-1:0] act_cond;
  logic [AFSG_W-1:0] flt_cond;
  logic [AFSG_W-1:0] act_new;
  logic [AFSG_W-1:0] flt_new;
  logic              rd_req;
  logic              wr_req;
  logic              act_clr;
  logic              flt_clr;

  // ------------------------------------------------------------
  // Condition words and transition filters
  // ------------------------------------------------------------
  afsg_cond_map u_cond (
    .ref_clk                  (ref_clk),
    .reset                    (reset),
    .ref_clock_unlocked       (ref_clock_unlocked),
    .data_store_full          (data_store_full),
    .chan_b_offset_zeroing    (chan_b_offset_zeroing),
    .chan_a_offset_zeroing    (chan_a_offset_zeroing),
    .trigger_wait             (trigger_wait),
    .recording_active         (recording_active),
    .ext_trigger_sel          (ext_trigger_sel),
    .overtemp                 (overtemp),
    .ref_signal_unlocked      (ref_signal_unlocked),
    .ratio_saturated          (ratio_saturated),
    .chan_b_pre_detector_sat  (chan_b_pre_detector_sat),
    .chan_b_post_detector_sat (chan_b_post_detector_sat),
    .chan_a_pre_detector_sat  (chan_a_pre_detector_sat),
    .chan_a_post_detector_sat (chan_a_post_detector_sat),
    .act_cond                 (act_cond),
    .flt_cond                 (flt_cond)
  );

  afsg_edge_filter #(.W(AFSG_W)) u_act_edge (
    .ref_clk (ref_clk),
    .reset   (reset),
    .cond    (act_cond),
    .rise_en (q.act_rise),
    .fall_en (q.act_fall),
    .events  (act_new)
  );

  afsg_edge_filter #(.W(AFSG_W)) u_flt_edge (
    .ref_clk (ref_clk),
    .reset   (reset),
    .cond    (flt_cond),
    .rise_en (q.flt_rise),
    .fall_en (q.flt_fall),
    .events  (flt_new)
  );

  // ------------------------------------------------------------
  // Command decode
  // ------------------------------------------------------------
  assign rd_req  = cmd_valid && !cmd_write;
  assign wr_req  = cmd_valid &&  cmd_write;
  assign act_clr = cls_pulse || (rd_req && cmd_sel == SEL_ACT_EVT);
  assign flt_clr = cls_pulse || (rd_req && cmd_sel == SEL_FLT_EVT);

  always_comb begin
    d           = q;
    d.rsp_valid = 1'b0;
    // New events are ORed after the clear so an edge in a clearing cycle survives
    d.act_evt   = (act_clr ? EVT_RST : q.act_evt) | act_new;
    d.flt_evt   = (flt_clr ? EVT_RST : q.flt_evt) | flt_new;
    if (wr_req) begin
      // Condition and event words are read-only; writes to them are dropped
      case (cmd_sel)
        SEL_ACT_MASK: d.act_mask = cmd_wdata;
        SEL_ACT_RISE: d.act_rise = cmd_wdata;
        SEL_ACT_FALL: d.act_fall = cmd_wdata;
        SEL_FLT_MASK: d.flt_mask = cmd_wdata;
        SEL_FLT_RISE: d.flt_rise = cmd_wdata;
        SEL_FLT_FALL: d.flt_fall = cmd_wdata;
        default: begin
        end
      endcase
    end
    if (rd_req) begin
      d.rsp_valid = 1'b1;
      case (cmd_sel)
        SEL_ACT_COND: d.rsp_data = act_cond;
        SEL_ACT_EVT:  d.rsp_data = q.act_evt;
        SEL_ACT_MASK: d.rsp_data = q.act_mask;
        SEL_ACT_RISE: d.rsp_data = q.act_rise;
        SEL_ACT_FALL: d.rsp_data = q.act_fall;
        SEL_FLT_COND: d.rsp_data = flt_cond;
        SEL_FLT_EVT:  d.rsp_data = q.flt_evt;
        SEL_FLT_MASK: d.rsp_data = q.flt_mask;
        SEL_FLT_RISE: d.rsp_data = q.flt_rise;
        SEL_FLT_FALL: d.rsp_data = q.flt_fall;
        default:      d.rsp_data = '0;
      endcase
    end
    // Registered so the summary lines up with the event word it reflects
    d.summary = |(d.act_evt & d.act_mask);
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      q <= TOP_RST;
    end else begin
      q <= d;
    end
  end

  assign rsp_valid        = q.rsp_valid;
  assign rsp_data         = q.rsp_data;
  assign activity_summary = q.summary;

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  a_unused_zero: assert property (@(posedge ref_clk) disable iff (reset)
    ((act_cond & ~ACT_USED_MASK) == '0) && ((flt_cond & ~FLT_USED_MASK) == '0))
    else $error("unassigned condition bit is set");

  a_ref_unlock_bit: assert property (@(posedge ref_clk) disable iff (reset)
    ##1 (act_cond[ACT_BIT_REF_UNLOCK] == $past(ref_clock_unlocked)) &&
        (act_cond[ACT_BIT_STORE_FULL] == $past(data_store_full)))
    else $error("activity bits 12 or 10 do not follow their source");

  a_trig_forces_rec: assert property (@(posedge ref_clk) disable iff (reset)
    ext_trigger_sel |=> !act_cond[ACT_BIT_RECORDING])
    else $error("recording bit set under external trigger");

  a_overtemp_bit: assert property (@(posedge ref_clk) disable iff (reset)
    (overtemp && !$past(overtemp)) |=> flt_cond[FLT_BIT_OVERTEMP] ##1 1'b1)
    else $error("overtemp bit missed");

  a_rise_sets_evt: assert property (@(posedge ref_clk) disable iff (reset)
    ($rose(act_cond[ACT_BIT_TRIG_WAIT]) && q.act_rise[ACT_BIT_TRIG_WAIT])
      |=> q.act_evt[ACT_BIT_TRIG_WAIT])
    else $error("rising edge did not set event bit");

  a_fall_only_sets: assert property (@(posedge ref_clk) disable iff (reset)
    ($fell(flt_cond[FLT_BIT_RATIO_SAT]) && q.flt_fall[FLT_BIT_RATIO_SAT] && !flt_clr)
      |=> q.flt_evt[FLT_BIT_RATIO_SAT])
    else $error("falling edge did not set fault event bit");

  a_latch_holds: assert property (@(posedge ref_clk) disable iff (reset)
    !act_clr |=> ((q.act_evt & $past(q.act_evt)) == $past(q.act_evt)))
    else $error("activity event bit dropped without a clear");

  a_read_returns: assert property (@(posedge ref_clk) disable iff (reset)
    (rd_req && cmd_sel == SEL_FLT_EVT) |=> rsp_valid && (rsp_data == $past(q.flt_evt)))
    else $error("fault event read returned wrong value");

  a_read_clears: assert property (@(posedge ref_clk) disable iff (reset)
    (rd_req && cmd_sel == SEL_ACT_EVT) |=> (q.act_evt == $past(act_new)))
    else $error("activity event word not cleared by read");

  a_cls_clears: assert property (@(posedge ref_clk) disable iff (reset)
    cls_pulse |=> (q.flt_evt == $past(flt_new)) && (q.act_evt == $past(act_new)))
    else $error("clear-status did not clear event words");

  a_mask_stable: assert property (@(posedge ref_clk) disable iff (reset)
    !(wr_req && (cmd_sel == SEL_ACT_MASK || cmd_sel == SEL_FLT_MASK))
      |=> $stable(q.act_mask) && $stable(q.flt_mask))
    else $error("mask changed without a host write");

  a_summary_track: assert property (@(posedge ref_clk) disable iff (reset)
    activity_summary == |(q.act_evt & q.act_mask))
    else $error("activity summary disagrees with enabled events");

  a_zeroing_bits: assert property (@(posedge ref_clk) disable iff (reset)
    ##1 (act_cond[ACT_BIT_A_ZEROING] == $past(chan_a_offset_zeroing)) &&
        (act_cond[ACT_BIT_B_ZEROING] == $past(chan_b_offset_zeroing)))
    else $error("activity zeroing bits do not follow their source");

  a_wait_rec_bits: assert property (@(posedge ref_clk) disable iff (reset)
    ##1 (act_cond[ACT_BIT_TRIG_WAIT] == $past(trigger_wait)) &&
        (act_cond[ACT_BIT_RECORDING] ==
         ($past(recording_active) && !$past(ext_trigger_sel))))
    else $error("trigger wait or recording bit does not follow its source");

  a_fault_state_bits: assert property (@(posedge ref_clk) disable iff (reset)
    ##1 (flt_cond[FLT_BIT_OVERTEMP] == $past(overtemp)) &&
        (flt_cond[FLT_BIT_SIG_UNLOCK] == $past(ref_signal_unlocked)) &&
        (flt_cond[FLT_BIT_RATIO_SAT] == $past(ratio_saturated)))
    else $error("fault state bits do not follow their source");

  a_pre_sat_bits: assert property (@(posedge ref_clk) disable iff (reset)
    ##1 (flt_cond[FLT_BIT_A_PRE_SAT] == $past(chan_a_pre_detector_sat)) &&
        (flt_cond[FLT_BIT_B_PRE_SAT] == $past(chan_b_pre_detector_sat)))
    else $error("pre-detector saturation bits do not follow their source");

  a_post_sat_bits: assert property (@(posedge ref_clk) disable iff (reset)
    ##1 (flt_cond[FLT_BIT_A_POST_SAT] == $past(chan_a_post_detector_sat)) &&
        (flt_cond[FLT_BIT_B_POST_SAT] == $past(chan_b_post_detector_sat)))
    else $error("post-detector saturation bits do not follow their source");

  a_act_edge_sets: assert property (@(posedge ref_clk) disable iff (reset)
    ##1 ((~q.act_evt &
          (($past(act_cond) & ~$past(act_cond, 2) & $past(q.act_rise)) |
           (~$past(act_cond) & $past(act_cond, 2) & $past(q.act_fall)))) == '0))
    else $error("qualified activity edge did not set its event bit");

  a_act_no_spurious: assert property (@(posedge ref_clk) disable iff (reset)
    ##1 ((q.act_evt & ~$past(q.act_evt) &
          ~(($past(act_cond) & ~$past(act_cond, 2) & $past(q.act_rise)) |
            (~$past(act_cond) & $past(act_cond, 2) & $past(q.act_fall)))) == '0))
    else $error("activity event bit set without a qualified edge");

  a_cond_read_value: assert property (@(posedge ref_clk) disable iff (reset)
    (rd_req && cmd_sel == SEL_ACT_COND) |=> rsp_valid && (rsp_data == $past(act_cond)))
    else $error("condition read returned wrong value");

  a_mask_write: assert property (@(posedge ref_clk) disable iff (reset)
    (wr_req && cmd_sel == SEL_ACT_MASK) |=> (q.act_mask == $past(cmd_wdata)))
    else $error("activity mask did not take the written value");

  a_answer_pulse: assert property (@(posedge ref_clk) disable iff (reset)
    ##1 (rsp_valid == $past(rd_req)))
    else $error("read answer strobe out of step with the request");

  a_reset_zero: assert property (@(posedge ref_clk)
    $fell(reset) |-> (q.act_evt == '0) && (q.flt_evt == '0) &&
                     (q.act_mask == '0) && (q.flt_mask == '0))
    else $error("event or mask word nonzero after reset");

endmodule // afsg_status_top
`default_nettype wire

/* shared/afsg_pkg.sv */
// Shared constants for the activity and fault status groups
package afsg_pkg;

  // ------------------------------------------------------------
  // Word width
  // ------------------------------------------------------------
  localparam int unsigned AFSG_W = 16;

  // ------------------------------------------------------------
  // Activity condition bit positions
  // ------------------------------------------------------------
  localparam int unsigned ACT_BIT_REF_UNLOCK  = 12;
  localparam int unsigned ACT_BIT_STORE_FULL  = 10;
  localparam int unsigned ACT_BIT_B_ZEROING   = 8;
  localparam int unsigned ACT_BIT_A_ZEROING   = 7;
  localparam int unsigned ACT_BIT_TRIG_WAIT   = 5;
  localparam int unsigned ACT_BIT_RECORDING   = 4;

  // ------------------------------------------------------------
  // Fault condition bit positions
  // ------------------------------------------------------------
  localparam int unsigned FLT_BIT_OVERTEMP    = 8;
  localparam int unsigned FLT_BIT_SIG_UNLOCK  = 6;
  localparam int unsigned FLT_BIT_RATIO_SAT   = 4;
  localparam int unsigned FLT_BIT_B_PRE_SAT   = 3;
  localparam int unsigned FLT_BIT_B_POST_SAT  = 2;
  localparam int unsigned FLT_BIT_A_PRE_SAT   = 1;
  localparam int unsigned FLT_BIT_A_POST_SAT  = 0;

  // Bits that carry a condition; all others read zero
  localparam logic [AFSG_W-1:0] ACT_USED_MASK = 16'h15B0;
  localparam logic [AFSG_W-1:0] FLT_USED_MASK = 16'h015F;

  // ------------------------------------------------------------
  // Values after reset
  // ------------------------------------------------------------
  localparam logic [AFSG_W-1:0] EVT_RST    = 16'h0000;
  localparam logic [AFSG_W-1:0] MASK_RST   = 16'h0000;
  localparam logic [AFSG_W-1:0] FILTER_RST = 16'h0000;
  localparam logic [AFSG_W-1:0] COND_RST   = 16'h0000;

  // ------------------------------------------------------------
  // Register select codes on the command port
  // ------------------------------------------------------------
  localparam logic [3:0] SEL_ACT_COND = 4'h0;
  localparam logic [3:0] SEL_ACT_EVT  = 4'h1;
  localparam logic [3:0] SEL_ACT_MASK = 4'h2;
  localparam logic [3:0] SEL_ACT_RISE = 4'h3;
  localparam logic [3:0] SEL_ACT_FALL = 4'h4;
  localparam logic [3:0] SEL_FLT_COND = 4'h5;
  localparam logic [3:0] SEL_FLT_EVT  = 4'h6;
  localparam logic [3:0] SEL_FLT_MASK = 4'h7;
  localparam logic [3:0] SEL_FLT_RISE = 4'h8;
  localparam logic [3:0] SEL_FLT_FALL = 4'h9;

endpackage

/* logic/afsg_cond_map.sv */
// Samples instrument state flags into the two condition words
`timescale 1ns/1ps
`default_nettype none
module afsg_cond_map
  import afsg_pkg::*;
(
  input  wire logic              ref_clk,
  input  wire logic              reset,
  input  wire logic              ref_clock_unlocked,
  input  wire logic              data_store_full,
  input  wire logic              chan_b_offset_zeroing,
  input  wire logic              chan_a_offset_zeroing,
  input  wire logic              trigger_wait,
  input  wire logic              recording_active,
  input  wire logic              ext_trigger_sel,
  input  wire logic              overtemp,
  input  wire logic              ref_signal_unlocked,
  input  wire logic              ratio_saturated,
  input  wire logic              chan_b_pre_detector_sat,
  input  wire logic              chan_b_post_detector_sat,
  input  wire logic              chan_a_pre_detector_sat,
  input  wire logic              chan_a_post_detector_sat,
  output logic [AFSG_W-1:0]      act_cond,
  output logic [AFSG_W-1:0]      flt_cond
);

  typedef struct packed {
    logic [AFSG_W-1:0] act;
    logic [AFSG_W-1:0] flt;
  } afsg_cond_state_t;

  afsg_cond_state_t q;
  afsg_cond_state_t d;

  // Unassigned positions are never written, so they stay zero
  always_comb begin
    d = '{act: COND_RST, flt: COND_RST};
    d.act[ACT_BIT_REF_UNLOCK] = ref_clock_unlocked;
    d.act[ACT_BIT_STORE_FULL] = data_store_full;
    d.act[ACT_BIT_B_ZEROING]  = chan_b_offset_zeroing;
    d.act[ACT_BIT_A_ZEROING]  = chan_a_offset_zeroing;
    d.act[ACT_BIT_TRIG_WAIT]  = trigger_wait;
    d.act[ACT_BIT_RECORDING]  = recording_active && !ext_trigger_sel;
    d.flt[FLT_BIT_OVERTEMP]   = overtemp;
    d.flt[FLT_BIT_SIG_UNLOCK] = ref_signal_unlocked;
    d.flt[FLT_BIT_RATIO_SAT]  = ratio_saturated;
    d.flt[FLT_BIT_B_PRE_SAT]  = chan_b_pre_detector_sat;
    d.flt[FLT_BIT_A_PRE_SAT]  = chan_a_pre_detector_sat;
    d.flt[FLT_BIT_B_POST_SAT] = chan_b_post_detector_sat;
    d.flt[FLT_BIT_A_POST_SAT] = chan_a_post_detector_sat;
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      q <= '{act: COND_RST, flt: COND_RST};
    end else begin
      q <= d;
    end
  end

  assign act_cond = q.act;
  assign flt_cond = q.flt;

endmodule // afsg_cond_map
`default_nettype wire

/* logic/afsg_edge_filter.sv */
// Per-bit transition filter: turns condition edges into event pulses
`timescale 1ns/1ps
`default_nettype none
module afsg_edge_filter
  import afsg_pkg::*;
#(
  parameter int unsigned W = AFSG_W
) (
  input  wire logic          ref_clk,
  input  wire logic          reset,
  input  wire logic [W-1:0]  cond,
  input  wire logic [W-1:0]  rise_en,
  input  wire logic [W-1:0]  fall_en,
  output logic [W-1:0]       events
);

  if (W < 1 || W > AFSG_W) begin : g_bad_width
    $error("afsg_edge_filter: W out of range");
  end

  typedef struct packed {
    logic [W-1:0] prev;
  } afsg_edge_state_t;

  afsg_edge_state_t q;
  afsg_edge_state_t d;

  always_comb begin
    d      = q;
    d.prev = cond;
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      q <= '{prev: '0};
    end else begin
      q <= d;
    end
  end

  // Event is a one-cycle pulse in the cycle the condition rises (rise_en set) or falls (fall_en set) from its last value
  for (genvar i = 0; i < W; i++) begin : g_bit
    assign events[i] = (rise_en[i] &&  cond[i] && !q.prev[i]) ||
                       (fall_en[i] && !cond[i] &&  q.prev[i]);
  end

endmodule // afsg_edge_filter
`default_nettype wire

/* test/afsg_status_top_bench.sv */
// Self-checking bench for the activity and fault status groups
`timescale 1ns/1ps
`default_nettype none
module afsg_status_top_bench;
  import afsg_pkg::*;

  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic              ref_clk;
  logic              reset;
  logic [13:0]       flags;
  logic              cmd_valid;
  logic              cmd_write;
  logic [3:0]        cmd_sel;
  logic [AFSG_W-1:0] cmd_wdata;
  logic              cls_pulse;
  logic              rsp_valid;
  logic [AFSG_W-1:0] rsp_data;
  logic              activity_summary;
  int                n_errors;
  int                total_checks;
  // Reference state, indexed by register select
  logic [AFSG_W-1:0] m_reg [10];
  logic [AFSG_W-1:0] m_ap;
  logic [AFSG_W-1:0] m_fp;
  logic [AFSG_W-1:0] m_rd;
  logic              m_rv;

  afsg_status_top u_dut (
    .ref_clk                  (ref_clk),
    .reset                    (reset),
    .ref_clock_unlocked       (flags[0]),
    .data_store_full          (flags[1]),
    .chan_b_offset_zeroing    (flags[2]),
    .chan_a_offset_zeroing    (flags[3]),
    .trigger_wait             (flags[4]),
    .recording_active         (flags[5]),
    .ext_trigger_sel          (flags[6]),
    .overtemp                 (flags[7]),
    .ref_signal_unlocked      (flags[8]),
    .ratio_saturated          (flags[9]),
    .chan_b_pre_detector_sat  (flags[10]),
    .chan_b_post_detector_sat (flags[11]),
    .chan_a_pre_detector_sat  (flags[12]),
    .chan_a_post_detector_sat (flags[13]),
    .cmd_valid                (cmd_valid),
    .cmd_write                (cmd_write),
    .cmd_sel                  (cmd_sel),
    .cmd_wdata                (cmd_wdata),
    .cls_pulse                (cls_pulse),
    .rsp_valid                (rsp_valid),
    .rsp_data                 (rsp_data),
    .activity_summary         (activity_summary)
  );

  // ----------------------------------------------------------------
  // Expected condition words
  // ----------------------------------------------------------------
  function automatic logic [AFSG_W-1:0] act_map(input logic [13:0] f);
    logic [AFSG_W-1:0] v;
    v = 16'h0000;
    v[12] = f[0];
    v[10] = f[1];
    v[8] = f[2];
    v[7] = f[3];
    v[5] = f[4];
    v[4] = f[5] & ~f[6];
    return v;
  endfunction

  function automatic logic [AFSG_W-1:0] flt_map(input logic [13:0] f);
    logic [AFSG_W-1:0] v;
    v = 16'h0000;
    v[8] = f[7];
    v[6] = f[8];
    v[4] = f[9];
    v[3] = f[10];
    v[1] = f[12];
    v[2] = f[11];
    v[0] = f[13];
    return v;
  endfunction

  // ----------------------------------------------------------------
  // Cycle model; sees inputs as they stood before each edge
  // ----------------------------------------------------------------
  always @(posedge ref_clk or posedge reset) begin : model
    logic [AFSG_W-1:0] na;
    logic [AFSG_W-1:0] nf;
    logic              rd1;
    logic              rd6;
    na = (m_reg[3] & m_reg[0] & ~m_ap) | (m_reg[4] & ~m_reg[0] & m_ap);
    nf = (m_reg[8] & m_reg[5] & ~m_fp) | (m_reg[9] & ~m_reg[5] & m_fp);
    rd1 = cmd_valid && !cmd_write && (cmd_sel == 4'h1);
    rd6 = cmd_valid && !cmd_write && (cmd_sel == 4'h6);
    if (reset) begin
      for (int i = 0; i < 10; i++) m_reg[i] <= 16'h0000;
      m_ap <= 16'h0000;
      m_fp <= 16'h0000;
      m_rd <= 16'h0000;
      m_rv <= 1'b0;
    end else begin
      m_ap <= m_reg[0];
      m_fp <= m_reg[5];
      m_reg[0] <= act_map(flags);
      m_reg[5] <= flt_map(flags);
      m_reg[1] <= ((cls_pulse || rd1) ? 16'h0000 : m_reg[1]) | na;
      m_reg[6] <= ((cls_pulse || rd6) ? 16'h0000 : m_reg[6]) | nf;
      m_rv <= cmd_valid && !cmd_write;
      if (cmd_valid && !cmd_write) m_rd <= (cmd_sel < 4'ha) ? m_reg[cmd_sel] : 16'h0000;
      if (cmd_valid && cmd_write && (cmd_sel inside {4'h2, 4'h3, 4'h4, 4'h7, 4'h8, 4'h9}))
        m_reg[cmd_sel] <= cmd_wdata;
    end
  end

  // ----------------------------------------------------------------
  // Compare tasks
  // ----------------------------------------------------------------
  task automatic chk_word(input logic [AFSG_W-1:0] got, input logic [AFSG_W-1:0] exp,
                          input string what);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp, input string what);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: %s got %b expected %b", $time, what, got, exp);
    end
  endtask

  // Outputs settle well before the falling edge
  always @(negedge ref_clk) begin
    chk_bit(rsp_valid, m_rv, "read answer strobe");
    chk_word(rsp_data, m_rd, "answer word");
    chk_bit(activity_summary, |(m_reg[1] & m_reg[2]), "summary bit");
  end

  // ----------------------------------------------------------------
  // Drivers; cmd leaves the strobe up so commands can run back to back
  // ----------------------------------------------------------------
  task automatic cmd(input logic wr, input logic [3:0] sel, input logic [AFSG_W-1:0] d);
    cmd_valid <= 1'b1;
    cmd_write <= wr;
    cmd_sel <= sel;
    cmd_wdata <= d;
    @(posedge ref_clk);
  endtask

  task automatic idle(input int n);
    cmd_valid <= 1'b0;
    cls_pulse <= 1'b0;
    repeat (n) @(posedge ref_clk);
  endtask

  task automatic rd(input logic [3:0] sel, input logic [AFSG_W-1:0] exp);
    cmd(1'b0, sel, 16'($urandom));
    cmd_valid <= 1'b0;
    #1;
    chk_word(rsp_data, exp, "read value");
    @(posedge ref_clk);
  endtask

  task automatic end_of_test();
    if (n_errors == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Clock, watchdog, main sequence
  // ----------------------------------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  initial begin
    repeat (20000) @(posedge ref_clk);
    n_errors++;
    $display("unexpected at %0t: run did not finish", $time);
    end_of_test();
  end

  initial begin : main
    logic [3:0]        rw_sel [6];
    logic [AFSG_W-1:0] v;
    logic [13:0]       f;
    rw_sel = '{4'h2, 4'h3, 4'h4, 4'h7, 4'h8, 4'h9};
    n_errors = 0;
    total_checks = 0;
    reset = 1'b1;
    flags = 14'h0000;
    cmd_valid = 1'b0;
    cmd_write = 1'b0;
    cmd_sel = 4'h0;
    cmd_wdata = 16'h0000;
    cls_pulse = 1'b0;
    void'($urandom(5356));
    repeat (16) @(posedge ref_clk);
    reset <= 1'b0;
    @(posedge ref_clk);
    // Every select reads zero after power-on, unmapped ones included
    for (int s = 0; s < 16; s++) rd(4'(s), 16'h0000);
    // Writable words keep what was written, even across clear-status
    for (int i = 0; i < 6; i++) begin
      v = 16'($urandom);
      cmd(1'b1, rw_sel[i], v);
      cmd_valid <= 1'b0;
      cls_pulse <= 1'b1;
      @(posedge ref_clk);
      idle(2);
      rd(rw_sel[i], v);
    end
    cmd(1'b1, 4'h1, 16'hffff);
    cmd(1'b1, 4'h0, 16'hffff);
    idle(2);
    rd(4'h1, 16'h0000);
    rd(4'h0, 16'h0000);
    // Condition mapping: walking ones, recording under external trigger, then random mixes; activity word read twice, fault word once
    for (int i = 0; i < 54; i++) begin
      f = (i < 14) ? 14'(1 << i) : ((i == 14) ? 14'h0060 : 14'($urandom));
      flags <= f;
      idle(2);
      rd(4'h0, act_map(f));
      rd(4'h0, act_map(f));
      rd(4'h5, flt_map(f));
    end
    // Filter modes on trigger wait and overtemp, summary through the mask
    flags <= 14'h0000;
    cmd(1'b1, 4'h2, 16'h0020);
    for (int m = 0; m < 4; m++) begin
      cmd(1'b1, 4'h3, m[0] ? 16'h0020 : 16'h0000);
      cmd(1'b1, 4'h4, m[1] ? 16'h0020 : 16'h0000);
      cmd(1'b1, 4'h8, m[0] ? 16'h0100 : 16'h0000);
      cmd(1'b1, 4'h9, m[1] ? 16'h0100 : 16'h0000);
      idle(3);
      cmd(1'b0, 4'h1, 16'h0000);
      cmd(1'b0, 4'h6, 16'h0000);
      flags <= 14'h0090;
      idle(6);
      chk_bit(activity_summary, m[0], "summary after rise");
      rd(4'h1, m[0] ? 16'h0020 : 16'h0000);
      rd(4'h6, m[0] ? 16'h0100 : 16'h0000);
      rd(4'h1, 16'h0000);
      chk_bit(activity_summary, 1'b0, "summary after clear");
      flags <= 14'h0000;
      idle(6);
      rd(4'h1, m[1] ? 16'h0020 : 16'h0000);
      rd(4'h6, m[1] ? 16'h0100 : 16'h0000);
    end
    // Clear-status empties both event words
    flags <= 14'h0090;
    idle(4);
    cls_pulse <= 1'b1;
    @(posedge ref_clk);
    idle(3);
    rd(4'h1, 16'h0000);
    rd(4'h6, 16'h0000);
    // A read-clear in the cycle an edge is detected keeps the new event
    flags <= 14'h0000;
    @(posedge ref_clk);
    cmd(1'b0, 4'h1, 16'h0000);
    rd(4'h1, 16'h0020);
    // Random traffic against the cycle model
    for (int i = 0; i < 400; i++) begin
      flags <= 14'($urandom);
      cls_pulse <= !cls_pulse && ($urandom % 16 == 0);
      cmd_valid <= 1'($urandom);
      cmd_write <= 1'($urandom);
      cmd_sel <= 4'($urandom);
      cmd_wdata <= 16'($urandom);
      @(posedge ref_clk);
    end
    idle(4);
    end_of_test();
  end

endmodule // afsg_status_top_bench
`default_nettype wire
